// File: pdim_defs.svh
// register indices, field positions and reset values of the port settings
`ifndef PDIM_DEFS_SVH
`define PDIM_DEFS_SVH
`define PDIM_IDX_P0MODE 8'h8F
`define PDIM_IDX_PORT2_DIRECTION_AND_PORT0_PRIORITY 8'hFF
`define PDIM_IDX_CFG 8'h90
`define PDIM_PRI_HI 7
`define PDIM_PRI_LO 6
`define PDIM_DIR_UNUSED 5
`define PDIM_DIR_HI 4
`define PDIM_CFG_POL 0
`define PDIM_CFG_LOC_HI 3
`define PDIM_CFG_LOC_LO 1
`define PDIM_LOC_SA 0
`define PDIM_LOC_SB 1
`define PDIM_LOC_T1 2
`define PDIM_RST_MODE 8'h00
`define PDIM_RST_DIR 5'h00
`define PDIM_RST_PRI 2'h0
`define PDIM_RST_LOC 3'h0
`define PDIM_PRI_A_OVER_B 2'h0
`define PDIM_PRI_B_OVER_A 2'h1
`define PDIM_PRI_T01_OVER_B 2'h2
`define PDIM_PRI_T2_OVER_A 2'h3
`endif

// File: pdim_pkg.sv
// types shared by the port direction and input mode block
`default_nettype none
package pdim_pkg;
    typedef enum logic [1:0] {
        PDIM_OWN_GPIO,
        PDIM_OWN_SA,
        PDIM_OWN_SB,
        PDIM_OWN_T1
    } pdim_owner_t;
endpackage
`default_nettype wire

// File: pdim_top.sv
// port 2 direction, port 0 input mode and port 0 pin ownership
// Function
// - priority field only matters where two or more peripherals share a pin.
// - priority 00 lets serial unit A win; 01 lets serial unit B win.
// - priority 10 lets timer 1 channels 0 and 1 beat serial unit B.
// - priority 11 lets timer 1 channel 2 beat serial unit A.
// - port 2 pins 0..4 direction bits, 0 input 1 output, reset 0.
// - port 0 input mode bits, 0 pull, 1 tristate, reset 0.
// - one shared bit picks pull-up (0) or pull-down (1) for port 0.
//
// Register access over Wishbone was decided locally.
`include "pdim_defs.svh"
`default_nettype none
module pdim_top
    import pdim_pkg::*;
#(
    parameter logic [7:0] SA_PINS = 8'h3C,
    parameter logic [7:0] SB_PINS = 8'h3C,
    parameter logic [7:0] T01_PINS = 8'h0C,
    parameter logic [7:0] T2_PINS = 8'h10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [4:0] p2_dir_o,
    output logic [7:0] p0_tristate_o,
    output logic p0_pull_down_o,
    output logic [15:0] p0_owner_o
);

    logic ack_reg;
    logic [31:0] dat_reg;
    logic [7:0] mode_reg;
    logic [4:0] dir_reg;
    logic [1:0] pri_reg;
    logic pol_reg;
    logic [2:0] loc_reg;

    // bus decode: word index is the register offset, low two bits ignored
    wire [7:0] word_idx = wb_adr_i[9:2];
    wire bus_req = wb_cyc_i && wb_stb_i;
    wire hit_mode = (word_idx == `PDIM_IDX_P0MODE);
    wire hit_dir = (word_idx == `PDIM_IDX_PORT2_DIRECTION_AND_PORT0_PRIORITY);
    wire hit_cfg = (word_idx == `PDIM_IDX_CFG);
    wire wr_fire = bus_req && wb_we_i && ack_reg && wb_sel_i[0];
    wire [7:0] wr_byte = wb_dat_i[7:0];

    // read selection; unmapped words read as zero
    wire [7:0] rd_byte =
        hit_mode ? mode_reg :
        hit_dir ? {pri_reg, 1'b0, dir_reg} :
        hit_cfg ? {4'h0, loc_reg, pol_reg} :
        8'h00;

    // single-wait-state answer: ack one cycle after the request appears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req && !ack_reg;
            dat_reg <= {{24{1'b0}}, rd_byte};
        end
    end

    // writes land on the edge where the master sees ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= `PDIM_RST_MODE;
            dir_reg <= `PDIM_RST_DIR;
            pri_reg <= `PDIM_RST_PRI;
            pol_reg <= 1'b0;
            loc_reg <= `PDIM_RST_LOC;
        end else if (wr_fire) begin
            if (hit_mode) begin
                mode_reg <= wr_byte;
            end else if (hit_dir) begin
                dir_reg <= wr_byte[`PDIM_DIR_HI:0];
                pri_reg <= wr_byte[`PDIM_PRI_HI:`PDIM_PRI_LO];
            end else if (hit_cfg) begin
                pol_reg <= wr_byte[`PDIM_CFG_POL];
                loc_reg <= wr_byte[`PDIM_CFG_LOC_HI:`PDIM_CFG_LOC_LO];
            end
        end
    end

    // pin-facing settings straight from the registers
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign p2_dir_o = dir_reg;
    assign p0_tristate_o = mode_reg;
    assign p0_pull_down_o = pol_reg;

    // ownership of one pin from the requests laid on it
    function automatic pdim_owner_t resolve(
        input logic [1:0] pri,
        input logic sa,
        input logic sb,
        input logic t01,
        input logic t2
    );
        pdim_owner_t own;
        own = PDIM_OWN_GPIO;
        case (pri)
            `PDIM_PRI_A_OVER_B: begin
                if (sa) own = PDIM_OWN_SA;
                else if (sb) own = PDIM_OWN_SB;
                else if (t01 || t2) own = PDIM_OWN_T1;
            end
            `PDIM_PRI_B_OVER_A: begin
                if (sb) own = PDIM_OWN_SB;
                else if (sa) own = PDIM_OWN_SA;
                else if (t01 || t2) own = PDIM_OWN_T1;
            end
            `PDIM_PRI_T01_OVER_B: begin
                if (t01) own = PDIM_OWN_T1;
                else if (sb) own = PDIM_OWN_SB;
                else if (sa) own = PDIM_OWN_SA;
                else if (t2) own = PDIM_OWN_T1;
            end
            default: begin
                if (t2) own = PDIM_OWN_T1;
                else if (sa) own = PDIM_OWN_SA;
                else if (sb) own = PDIM_OWN_SB;
                else if (t01) own = PDIM_OWN_T1;
            end
        endcase
        return own;
    endfunction

    // per-pin requests and registered owner
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            pdim_owner_t own_reg;
            pdim_owner_t own_next;
            wire req_sa = loc_reg[`PDIM_LOC_SA] && SA_PINS[gi];
            wire req_sb = loc_reg[`PDIM_LOC_SB] && SB_PINS[gi];
            wire req_t01 = loc_reg[`PDIM_LOC_T1] && T01_PINS[gi];
            wire req_t2 = loc_reg[`PDIM_LOC_T1] && T2_PINS[gi];
            wire [2:0] n_req = {2'b00, req_sa} + {2'b00, req_sb} +
                {2'b00, req_t01} + {2'b00, req_t2};
            // a lone requester wins whatever the priority says
            assign own_next =
                resolve(pri_reg, req_sa, req_sb, req_t01, req_t2);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    own_reg <= PDIM_OWN_GPIO;
                end else begin
                    own_reg <= own_next;
                end
            end
            assign p0_owner_o[2*gi +: 2] = own_reg;

            // lone serial B requester keeps its pin
            lone_owner_a: assert property (
                @(posedge clk_i) disable iff (rst_i)
                (n_req == 3'd1 && req_sb) |=> own_reg == PDIM_OWN_SB)
            else $error("lone serial B request lost its pin");
            // serial units contest; B also leads A at priority 10
            serial_contest_a: assert property (
                @(posedge clk_i) disable iff (rst_i)
                (req_sa && req_sb && !req_t01 && !req_t2) |=>
                own_reg == (($past(pri_reg) == `PDIM_PRI_B_OVER_A ||
                    $past(pri_reg) == `PDIM_PRI_T01_OVER_B) ?
                    PDIM_OWN_SB : PDIM_OWN_SA))
            else $error("wrong serial unit owns contested pin");
            // timer 1 ch0/1 beats serial B
            t01_wins_a: assert property (
                @(posedge clk_i) disable iff (rst_i)
                (pri_reg == `PDIM_PRI_T01_OVER_B && req_t01 && req_sb)
                |=> own_reg == PDIM_OWN_T1)
            else $error("timer 1 ch0/1 did not win over serial B");
            // timer 1 ch2 beats serial A
            t2_wins_a: assert property (
                @(posedge clk_i) disable iff (rst_i)
                (pri_reg == `PDIM_PRI_T2_OVER_A && req_t2 && req_sa)
                |=> own_reg == PDIM_OWN_T1)
            else $error("timer 1 ch2 did not win over serial A");
        end
    endgenerate

    // bus handshake and register write sequences
    sequence wr_dir_s;
        wr_fire && hit_dir;
    endsequence
    sequence wr_mode_s;
        wr_fire && hit_mode;
    endsequence
    sequence rd_dir_s;
        bus_req && !wb_we_i && hit_dir && !ack_reg ##1 ack_reg;
    endsequence

    ack_timing_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (bus_req && !ack_reg) |=> ack_reg ##1 !ack_reg)
    else $error("ack not a single pulse one cycle after request");

    dir_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_dir_s |=> p2_dir_o == $past(wr_byte[`PDIM_DIR_HI:0]))
    else $error("port 2 direction write not applied");

    dir_reset_a: assert property (
        @(posedge clk_i)
        rst_i |=> p2_dir_o == `PDIM_RST_DIR &&
            p0_tristate_o == `PDIM_RST_MODE)
    else $error("direction or mode not zero after reset");

    mode_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_mode_s |=> p0_tristate_o == $past(wr_byte))
    else $error("port 0 input mode write not applied");

    pull_select_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_fire && hit_cfg) |=>
        p0_pull_down_o == $past(wr_byte[`PDIM_CFG_POL]))
    else $error("pull polarity does not follow its bit");

    unused_bit_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_dir_s |-> wb_dat_o[`PDIM_DIR_UNUSED] == 1'b0)
    else $error("unused direction bit reads as one");

endmodule
`default_nettype wire

// File: pdim_pads.sv
// pad model of port 0: level each pin shows while it is an input
`default_nettype none
module pdim_pads (
    input wire logic clk_i,
    input wire logic [7:0] p0_tristate_i,
    input wire logic p0_pull_down_i,
    output logic [7:0] p0_level_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] float_reg = 8'h55;
    // a floating pin never holds a steady level
    always_ff @(posedge clk_i) begin
        float_reg <= ~float_reg;
    end
    // pulled pins sit at the shared pull level
    assign p0_level_o = (p0_tristate_i & float_reg)
        | (~p0_tristate_i & {8{~p0_pull_down_i}});
endmodule
`default_nettype wire

// File: tb_top.sv
// register and pin ownership tests of the port settings block
`include "pdim_defs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [3:0] sel_use = 4'h1;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack;
    logic [4:0] p2_dir;
    logic [7:0] p0_tri;
    logic [7:0] lvl;
    logic pull_dn;
    logic [15:0] owner;
    logic [15:0] own_exp [4] = '{16'h0550, 16'h0AA0, 16'h0AF0, 16'h0750};
    int error_cnt = 0;
    int n_compared = 0;
    // free running system clock
    always #12.5 clk_i = ~clk_i;
    pdim_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .p2_dir_o(p2_dir), .p0_tristate_o(p0_tri),
        .p0_pull_down_o(pull_dn), .p0_owner_o(owner));
    pdim_pads i_pads (.clk_i(clk_i), .p0_tristate_i(p0_tri),
        .p0_pull_down_i(pull_dn), .p0_level_o(lvl));
    // one classic cycle; held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] i,
        input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= sel_use;
        adr <= {i, 2'b00};
        wdat <= {24'h00_0000, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask
    // owners follow a write one edge after ack
    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("Error at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // hang guard, far beyond the length of the tests
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, `PDIM_IDX_P0MODE, 8'h00);
        chk(q, 32'h0000_0000);
        bus(1'b0, `PDIM_IDX_PORT2_DIRECTION_AND_PORT0_PRIORITY, 8'h00);
        chk(q, 32'h0000_0000);
        chk(32'(p2_dir), 32'h0000_0000);
        $display("test reset done");
        bus(1'b1, `PDIM_IDX_P0MODE, 8'hA5);
        bus(1'b0, `PDIM_IDX_P0MODE, 8'h00);
        chk(q, 32'h0000_00A5);
        chk(32'(p0_tri), 32'h0000_00A5);
        // a write without the low byte lane must leave the mode untouched
        sel_use = 4'h0;
        bus(1'b1, `PDIM_IDX_P0MODE, 8'h5A);
        sel_use = 4'h1;
        bus(1'b0, `PDIM_IDX_P0MODE, 8'h00);
        chk(q, 32'h0000_00A5);
        bus(1'b1, `PDIM_IDX_PORT2_DIRECTION_AND_PORT0_PRIORITY, 8'hFF);
        bus(1'b0, `PDIM_IDX_PORT2_DIRECTION_AND_PORT0_PRIORITY, 8'h00);
        chk(q, 32'h0000_00DF);
        chk(32'(p2_dir), 32'h0000_001F);
        bus(1'b0, 8'h10, 8'h00);
        chk(q, 32'h0000_0000);
        $display("test registers done");
        bus(1'b1, `PDIM_IDX_P0MODE, 8'h0F);
        bus(1'b1, `PDIM_IDX_CFG, 8'h00);
        settle();
        chk(32'(lvl[7:4]), 32'h0000_000F);
        bus(1'b1, `PDIM_IDX_CFG, 8'h01);
        settle();
        chk(32'(pull_dn), 32'h0000_0001);
        chk(32'(lvl[7:4]), 32'h0000_0000);
        $display("test pull done");
        bus(1'b1, `PDIM_IDX_CFG, 8'h04);
        bus(1'b1, `PDIM_IDX_PORT2_DIRECTION_AND_PORT0_PRIORITY, 8'h00);
        settle();
        chk(32'(owner), 32'h0000_0AA0);
        bus(1'b1, `PDIM_IDX_CFG, 8'h0E);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `PDIM_IDX_PORT2_DIRECTION_AND_PORT0_PRIORITY, {2'(i), 6'h00});
            settle();
            chk(32'(owner), 32'(own_exp[i]));
        end
        $display("test owners done");
        results();
    end
endmodule
`default_nettype wire
